/* File: verilog/usc_pkg.sv */
// usc_pkg: constants, encodings and state types of the serial status/control block
// assumes: one 200 MHz core clock, word-indexed register port, 16-bit data
// Notes on behaviour
// - tx event: each load, buffer emptied, or done
// - ir polarity sets encoded idle level
// - break sends start, twelve zeros, stop; self-clears
// - tx enable drives pin; clearing aborts, flushes
// - buffer full flag when no slot free
// - all-empty flag needs shifter and buffer empty
// - rx event at four, three, or every character
// - address detect keeps only ninth-bit-set characters in 9N format
// - rx idle flag high when not receiving
// - parity flag belongs to head character
// - framing flag belongs to head character
// - overrun sets on overflow; clearing flushes receiver
// - data available while rx buffer nonempty
// - status/control fields at fixed bit positions
// - reading rx data advances head and flags
// - break then sync: dummy, then sync follows
// - format codes: 9N, 8O, 8E, 8N
package usc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ   = 200;
  localparam int         BIT_NS    = 80;
  localparam logic [7:0] BIT_CYC   = 8'((BIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HALF_CYC  = BIT_CYC >> 1;
  localparam logic [7:0] IR_PULSE  = BIT_CYC >> 2;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] A_STA  = 4'h0;
  localparam logic [3:0] A_MODE = 4'h1;
  localparam logic [3:0] A_TXD  = 4'h2;
  localparam logic [3:0] A_RXD  = 4'h3;
  localparam logic [3:0] A_IST  = 4'h4;
  localparam logic [3:0] A_ICLR = 4'h5;
  localparam logic [3:0] A_IEN  = 4'h6;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int B_TXSEL1 = 15;
  localparam int B_TXINV  = 14;
  localparam int B_TXSEL0 = 13;
  localparam int B_BRK    = 11;
  localparam int B_TXEN   = 10;
  localparam int B_TXBF   = 9;
  localparam int B_TX_ALL_EMPTY   = 8;
  localparam int B_RXSEL  = 6;
  localparam int B_ADDRESS_DETECT_ENABLE  = 5;
  localparam int B_RX_IDLE_FLAG  = 4;
  localparam int B_PARITY_ERROR_FLAG   = 3;
  localparam int B_FRAMING_ERROR_FLAG   = 2;
  localparam int B_OVERRUN_FLAG   = 1;
  localparam int B_RXDA   = 0;
  localparam int B_IR_CODEC_ENABLE   = 12;
  localparam int B_FMT    = 1;
  localparam logic [15:0] STA_WMASK = 16'hECE0;
  localparam int I_TX  = 0;
  localparam int I_RX  = 1;
  localparam int I_ERR = 2;
  localparam int IRQ_W = 3;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TXSEL_EACH  = 2'b00;
  localparam logic [1:0] TXSEL_EMPTY = 2'b10;
  localparam logic [1:0] TXSEL_DONE  = 2'b01;
  localparam logic [1:0] RXSEL_FULL  = 2'b11;
  localparam logic [1:0] RXSEL_3Q    = 2'b10;
  localparam logic [1:0] FMT_9N      = 2'b11;
  localparam logic [1:0] FMT_8O      = 2'b10;
  localparam logic [1:0] FMT_8E      = 2'b01;
  localparam logic [1:0] FMT_8N      = 2'b00;
  // ----------------------------------------------------------------
  // fifo and frames
  // ----------------------------------------------------------------
  localparam int          FIFO_DEPTH = 4;
  localparam int          FIFO_W     = 11;
  localparam logic [2:0]  FIFO_FULL  = 3'h4;
  localparam int          H_PARITY_ERROR_FLAG     = 9;
  localparam int          H_FRAMING_ERROR_FLAG     = 10;
  localparam logic [13:0] BRK_FRAME  = 14'h2000;
  localparam logic [3:0]  BRK_BITS   = 4'hE;
  localparam logic [3:0]  BITS_8N    = 4'hA;
  localparam logic [3:0]  BITS_9     = 4'hB;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } usc_rx_t;
  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } usc_tx_t;
endpackage

/* File: verilog/usc_fifo_if.sv */
// usc_fifo_if: push/pop carrier between the control logic and a fifo
// assumes: all signals on the core clock
`timescale 1ns/100ps
interface usc_fifo_if;
  logic                       push;
  logic [usc_pkg::FIFO_W-1:0] wdata;
  logic                       pop;
  logic                       flush;
  logic [usc_pkg::FIFO_W-1:0] head;
  logic [2:0]                 count;
  logic                       full;
  logic                       empty;
  modport store (input push, wdata, pop, flush, output head, count, full, empty);
  modport user  (output push, wdata, pop, flush, input head, count, full, empty);
endinterface

/* File: verilog/usc_fifo.sv */
// usc_fifo: four-entry character fifo with flush
// assumes: caller never pushes when full; flush wins over push
`timescale 1ns/100ps
module usc_fifo (
  input wire logic  clk,    // core clock
  input wire logic  rst_n,  // sync reset, low
  usc_fifo_if.store f       // fifo port
);
  typedef struct packed {
    logic [usc_pkg::FIFO_DEPTH-1:0][usc_pkg::FIFO_W-1:0] mem;
    logic [1:0]                                          rd;
    logic [1:0]                                          wr;
    logic [2:0]                                          cnt;
  } usc_fifo_st_t;

  usc_fifo_st_t q;
  usc_fifo_st_t d;

  always_comb begin
    d = q;
    if (f.pop && q.cnt != 3'h0) begin
      d.rd  = q.rd + 2'h1;
      d.cnt = d.cnt - 3'h1;
    end
    if (f.push && q.cnt != usc_pkg::FIFO_FULL) begin
      d.mem[q.wr] = f.wdata;
      d.wr        = q.wr + 2'h1;
      d.cnt       = d.cnt + 3'h1;
    end
    if (f.flush) begin
      d.rd  = '0;
      d.wr  = '0;
      d.cnt = '0;
    end
    if (!rst_n) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign f.head  = q.mem[q.rd];
  assign f.count = q.cnt;
  assign f.full  = q.cnt == usc_pkg::FIFO_FULL;
  assign f.empty = q.cnt == 3'h0;
endmodule // usc_fifo

/* File: verilog/usc_top.sv */
// usc_top: serial port status/control, transmitter, receiver, interrupts
// assumes: register master per plain strobe port; RX_PIN asynchronous
`timescale 1ns/100ps
module usc_top (
  input  wire logic        CORE_CLK,   // core clock
  input  wire logic        NRST,       // sync reset, low
  input  wire logic [3:0]  ADDR,       // register index
  input  wire logic [15:0] WDATA,      // write data
  input  wire logic        WR,         // write strobe
  input  wire logic        RD,         // read strobe
  output logic      [15:0] RDATA,      // read data, cycle after RD
  input  wire logic        RX_PIN,     // serial input
  output logic             TX_PIN_O,   // serial output level
  output logic             TX_PIN_OE,  // serial output enable
  output logic             IRQ         // level interrupt
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]          sta;
    logic                 overrun_flag;
    logic                 ir_codec_enable;
    logic [1:0]           fmt;
    logic [2:0]           ist;
    logic [2:0]           ien;
    logic [15:0]          rdata;
    logic                 irq;
    logic                 txo;
    logic                 txoe;
    logic                 txen_p;
    usc_pkg::usc_tx_t     ts;
    logic [13:0]          frm;
    logic [3:0]           nleft;
    logic [7:0]           tcnt;
    logic                 brkf;
    usc_pkg::usc_rx_t     rs;
    logic [7:0]           rcnt;
    logic [3:0]           rbits;
    logic [8:0]           rsh;
    logic [1:0]           rxs;
  } usc_state_t;

  usc_state_t q;
  usc_state_t d;

  logic                       tx_push;
  logic                       tx_pop;
  logic                       tx_flush;
  logic                       rx_push;
  logic                       rx_pop;
  logic                       rx_flush;
  logic                       rx_commit;
  logic [usc_pkg::FIFO_W-1:0] rx_wdata;
  logic [2:0]                 ev;
  logic [2:0]                 iclr;
  logic                       oclr;
  logic                       ovf;
  logic [15:0]                stat;
  logic [1:0]                 txsel;
  logic [1:0]                 rxsel;
  logic [8:0]                 rdat;
  logic                       parity_error_flag;
  logic                       bitv;
  logic                       rxl;
  logic [3:0]                 nb;

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  usc_fifo_if txf ();
  usc_fifo_if rxf ();

  usc_fifo u_txf (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .f     (txf)
  );
  usc_fifo u_rxf (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .f     (rxf)
  );

  assign txf.push  = tx_push;
  assign txf.wdata = {2'b00, WDATA[8:0]};
  assign txf.pop   = tx_pop;
  assign txf.flush = tx_flush;
  assign rxf.push  = rx_push;
  assign rxf.wdata = rx_wdata;
  assign rxf.pop   = rx_pop;
  assign rxf.flush = rx_flush;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    tx_push   = 1'b0;
    tx_pop    = 1'b0;
    tx_flush  = 1'b0;
    rx_push   = 1'b0;
    rx_pop    = 1'b0;
    rx_flush  = 1'b0;
    rx_commit = 1'b0;
    ev        = '0;
    iclr      = '0;
    oclr      = 1'b0;
    ovf       = 1'b0;
    d.rxs     = {q.rxs[0], RX_PIN};
    rxl       = q.rxs[1];
    txsel     = {q.sta[usc_pkg::B_TXSEL1], q.sta[usc_pkg::B_TXSEL0]};
    rxsel     = q.sta[usc_pkg::B_RXSEL +: 2];
    nb        = (q.fmt == usc_pkg::FMT_8N) ? 4'h8 : 4'h9;

    // status word as software sees it
    stat = q.sta & usc_pkg::STA_WMASK;
    stat[usc_pkg::B_TXBF]  = txf.full;
    stat[usc_pkg::B_TX_ALL_EMPTY]  = txf.empty && q.ts == usc_pkg::TX_IDLE;
    stat[usc_pkg::B_RX_IDLE_FLAG] = q.rs == usc_pkg::RX_IDLE;
    stat[usc_pkg::B_PARITY_ERROR_FLAG]  = !rxf.empty && rxf.head[usc_pkg::H_PARITY_ERROR_FLAG];
    stat[usc_pkg::B_FRAMING_ERROR_FLAG]  = !rxf.empty && rxf.head[usc_pkg::H_FRAMING_ERROR_FLAG];
    stat[usc_pkg::B_OVERRUN_FLAG]  = q.overrun_flag;
    stat[usc_pkg::B_RXDA]  = !rxf.empty;

    // register writes
    if (WR) begin
      case (ADDR)
        usc_pkg::A_STA: begin
          d.sta = WDATA & usc_pkg::STA_WMASK;
          oclr  = q.overrun_flag && !WDATA[usc_pkg::B_OVERRUN_FLAG];
        end
        usc_pkg::A_MODE: begin
          d.ir_codec_enable = WDATA[usc_pkg::B_IR_CODEC_ENABLE];
          d.fmt  = WDATA[usc_pkg::B_FMT +: 2];
        end
        usc_pkg::A_TXD:  tx_push = !txf.full;
        usc_pkg::A_ICLR: iclr = WDATA[usc_pkg::IRQ_W-1:0];
        usc_pkg::A_IEN:  d.ien = WDATA[usc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // register reads; data stand one cycle only
    d.rdata = '0;
    if (RD) begin
      case (ADDR)
        usc_pkg::A_STA: d.rdata = stat;
        usc_pkg::A_MODE: begin
          d.rdata[usc_pkg::B_IR_CODEC_ENABLE]     = q.ir_codec_enable;
          d.rdata[usc_pkg::B_FMT +: 2] = q.fmt;
        end
        usc_pkg::A_RXD: begin
          d.rdata[8:0] = rxf.head[8:0];
          rx_pop       = !rxf.empty;
        end
        usc_pkg::A_IST: d.rdata[usc_pkg::IRQ_W-1:0] = q.ist;
        usc_pkg::A_IEN: d.rdata[usc_pkg::IRQ_W-1:0] = q.ien;
        default: ;
      endcase
    end

    // transmitter
    d.txen_p = q.sta[usc_pkg::B_TXEN];
    if (q.txen_p && !q.sta[usc_pkg::B_TXEN]) begin
      tx_flush = 1'b1;
    end
    unique case (q.ts)
      usc_pkg::TX_IDLE: begin
        if (q.sta[usc_pkg::B_TXEN] && !txf.empty) begin
          tx_pop = 1'b1;
          d.ts   = usc_pkg::TX_SHIFT;
          d.tcnt = '0;
          if (q.sta[usc_pkg::B_BRK]) begin
            d.frm   = usc_pkg::BRK_FRAME;
            d.nleft = usc_pkg::BRK_BITS;
            d.brkf  = 1'b1;
          end else begin
            d.frm      = '1;
            d.frm[0]   = 1'b0;
            d.frm[8:1] = txf.head[7:0];
            unique case (q.fmt)
              usc_pkg::FMT_9N: d.frm[9] = txf.head[8];
              usc_pkg::FMT_8O: d.frm[9] = ~^txf.head[7:0];
              usc_pkg::FMT_8E: d.frm[9] = ^txf.head[7:0];
              usc_pkg::FMT_8N: d.frm[9] = 1'b1;
            endcase
            d.nleft = (q.fmt == usc_pkg::FMT_8N) ? usc_pkg::BITS_8N : usc_pkg::BITS_9;
          end
          if (txsel == usc_pkg::TXSEL_EACH ||
              (txsel == usc_pkg::TXSEL_EMPTY && txf.count == 3'h1 && !tx_push)) begin
            ev[usc_pkg::I_TX] = 1'b1;
          end
        end
      end
      usc_pkg::TX_SHIFT: begin
        if (q.tcnt == usc_pkg::BIT_CYC - 8'h01) begin
          d.tcnt  = '0;
          d.frm   = {1'b1, q.frm[13:1]};
          d.nleft = q.nleft - 4'h1;
          if (q.nleft == 4'h1) begin
            d.ts = usc_pkg::TX_IDLE;
            if (q.brkf) begin
              d.brkf                = 1'b0;
              d.sta[usc_pkg::B_BRK] = 1'b0;
            end
            if (txsel == usc_pkg::TXSEL_DONE && txf.empty) begin
              ev[usc_pkg::I_TX] = 1'b1;
            end
          end
        end else begin
          d.tcnt = q.tcnt + 8'h01;
        end
      end
    endcase
    if (!q.sta[usc_pkg::B_TXEN]) begin
      d.ts   = usc_pkg::TX_IDLE;
      d.brkf = 1'b0;
    end

    // pin level, with optional ir pulse encoding
    bitv = (d.ts == usc_pkg::TX_SHIFT) ? d.frm[0] : 1'b1;
    if (d.ir_codec_enable) begin
      d.txo = (!bitv && d.tcnt < usc_pkg::IR_PULSE) ?
              !d.sta[usc_pkg::B_TXINV] : d.sta[usc_pkg::B_TXINV];
    end else begin
      d.txo = bitv;
    end
    d.txoe = d.sta[usc_pkg::B_TXEN];

    // receiver
    unique case (q.rs)
      usc_pkg::RX_IDLE: begin
        if (!rxl) begin
          d.rs   = usc_pkg::RX_START;
          d.rcnt = '0;
        end
      end
      usc_pkg::RX_START: begin
        if (q.rcnt == usc_pkg::HALF_CYC - 8'h01) begin
          d.rcnt  = '0;
          d.rbits = '0;
          d.rs    = rxl ? usc_pkg::RX_IDLE : usc_pkg::RX_DATA;
        end else begin
          d.rcnt = q.rcnt + 8'h01;
        end
      end
      usc_pkg::RX_DATA: begin
        if (q.rcnt == usc_pkg::BIT_CYC - 8'h01) begin
          d.rcnt  = '0;
          d.rsh   = {rxl, q.rsh[8:1]};
          d.rbits = q.rbits + 4'h1;
          if (q.rbits == nb - 4'h1) begin
            d.rs = usc_pkg::RX_STOP;
          end
        end else begin
          d.rcnt = q.rcnt + 8'h01;
        end
      end
      usc_pkg::RX_STOP: begin
        if (q.rcnt == usc_pkg::BIT_CYC - 8'h01) begin
          rx_commit = 1'b1;
          d.rs      = usc_pkg::RX_IDLE;
        end else begin
          d.rcnt = q.rcnt + 8'h01;
        end
      end
    endcase

    // received character with its own error flags
    unique case (q.fmt)
      usc_pkg::FMT_8N: rdat = {1'b0, q.rsh[8:1]};
      usc_pkg::FMT_9N: rdat = q.rsh;
      default:         rdat = {1'b0, q.rsh[7:0]};
    endcase
    parity_error_flag = (q.fmt == usc_pkg::FMT_8E && ^q.rsh) ||
           (q.fmt == usc_pkg::FMT_8O && !(^q.rsh));
    rx_wdata = {!rxl, parity_error_flag, rdat};
    if (rx_commit) begin
      if (q.sta[usc_pkg::B_ADDRESS_DETECT_ENABLE] && q.fmt == usc_pkg::FMT_9N && !rdat[8]) begin
        rx_push = 1'b0;
      end else if (rxf.full) begin
        ovf    = 1'b1;
        d.overrun_flag = 1'b1;
        ev[usc_pkg::I_ERR] = 1'b1;
      end else if (!q.overrun_flag) begin
        rx_push = 1'b1;
        if ((rxsel == usc_pkg::RXSEL_FULL && rxf.count == 3'h3) ||
            (rxsel == usc_pkg::RXSEL_3Q && rxf.count == 3'h2) ||
            !rxsel[1]) begin
          ev[usc_pkg::I_RX] = 1'b1;
        end
      end
    end
    // a new overflow in the clearing cycle keeps the flag
    if (oclr && !ovf) begin
      d.overrun_flag   = 1'b0;
      rx_flush = 1'b1;
      d.rs     = usc_pkg::RX_IDLE;
    end

    // interrupts; a new event beats a clear
    d.ist = (q.ist & ~iclr) | ev;
    d.irq = |(d.ist & d.ien);

    if (!NRST) begin
      d     = '0;
      d.txo = 1'b1;
      d.rxs = 2'b11;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    q <= d;
  end

  assign RDATA     = q.rdata;
  assign TX_PIN_O  = q.txo;
  assign TX_PIN_OE = q.txoe;
  assign IRQ       = q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [8:0] brk_len;
  always_ff @(posedge CORE_CLK) begin
    brk_len <= q.brkf ? brk_len + 9'h001 : 9'h000;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  wire rd_sta = RD && ADDR == usc_pkg::A_STA;

  chk_tx_event_each: assert property (tx_pop && txsel == usc_pkg::TXSEL_EACH && !iclr[0]
    |=> q.ist[usc_pkg::I_TX]) else $error("tx event missing");
  chk_ir_idle_level: assert property (q.ts == usc_pkg::TX_IDLE && q.ir_codec_enable
    |-> TX_PIN_O == q.sta[usc_pkg::B_TXINV]) else $error("ir idle level wrong");
  chk_break_length: assert property ($fell(q.brkf) && q.sta[usc_pkg::B_TXEN]
    |-> brk_len == 9'd224 && !q.sta[usc_pkg::B_BRK]) else $error("break length wrong");
  chk_tx_abort: assert property ($fell(q.sta[usc_pkg::B_TXEN])
    |=> txf.empty && q.ts == usc_pkg::TX_IDLE && !TX_PIN_OE) else $error("abort failed");
  chk_full_flag: assert property (rd_sta
    |=> RDATA[usc_pkg::B_TXBF] == $past(txf.full)) else $error("full flag wrong");
  chk_empty_flag: assert property (rd_sta |=> RDATA[usc_pkg::B_TX_ALL_EMPTY] ==
    $past(txf.empty && q.ts == usc_pkg::TX_IDLE)) else $error("empty flag wrong");
  chk_rx_event_3q: assert property (rx_push && rxsel == usc_pkg::RXSEL_3Q
    && rxf.count == 3'h2 |=> q.ist[usc_pkg::I_RX]) else $error("rx event missing");
  chk_addr_drop: assert property (rx_commit && q.sta[usc_pkg::B_ADDRESS_DETECT_ENABLE]
    && q.fmt == usc_pkg::FMT_9N && !rdat[8] |-> !rx_push) else $error("address kept");
  chk_idle_flag: assert property (rd_sta
    |=> RDATA[usc_pkg::B_RX_IDLE_FLAG] == $past(q.rs == usc_pkg::RX_IDLE)) else $error("idle wrong");
  chk_parity_error_flag_head: assert property (rd_sta |=> RDATA[usc_pkg::B_PARITY_ERROR_FLAG] ==
    $past(!rxf.empty && rxf.head[usc_pkg::H_PARITY_ERROR_FLAG])) else $error("parity flag wrong");
  chk_overrun_flag_flush: assert property (oclr && !ovf
    |=> rxf.empty && !q.overrun_flag && q.rs == usc_pkg::RX_IDLE) else $error("flush failed");
  chk_rx_pop: assert property (RD && ADDR == usc_pkg::A_RXD && !rxf.empty && !rx_push
    |=> rxf.count == $past(rxf.count) - 3'h1) else $error("pop failed");
  chk_irq_level: assert property (##1 IRQ == |(q.ist & q.ien))
    else $error("irq level wrong");

  cov_break_done: cover property ($fell(q.brkf) && q.sta[usc_pkg::B_TXEN]);
  cov_overrun:    cover property (ovf);
  cov_rx_full:    cover property (rx_push && rxf.count == 3'h3);
  cov_tx_done:    cover property (ev[usc_pkg::I_TX] && q.ts == usc_pkg::TX_SHIFT);
endmodule // usc_top

/* File: verif/usc_remote.sv */
// usc_remote: far-end serial transceiver model
// assumes: 16 core cycles a bit, line idles high
`timescale 1ns/100ps
module usc_remote (
  input  wire logic clk,     // core clock
  input  wire logic tx_o,    // block serial out
  input  wire logic tx_oe,   // block drives pin
  output logic      rx_line  // line into block
);
  logic [8:0] got_q[$];
  logic       line;
  // a released pin reads as the idle high level
  assign line = tx_oe ? tx_o : 1'b1;
  int         low_run = 0;
  int         max_low = 0;
  // ------------------
  // sender and decoder
  // ------------------
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      repeat (16) @(posedge clk);
    end
    rx_line <= 1'b1;
    @(posedge clk);
  endtask
  // decoded char keeps stop level in bit 8
  initial begin
    logic [8:0] c;
    rx_line = 1'b1;
    forever begin
      @(posedge clk iff !line);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (16) @(posedge clk);
        c[i] = line;
      end
      got_q.push_back(c);
      @(posedge clk iff line);
    end
  end
  // longest driven low stretch
  always @(posedge clk) begin
    if (!line) begin
      low_run <= low_run + 1;
    end else begin
      low_run <= 0;
      if (low_run > max_low) max_low <= low_run;
    end
  end
endmodule // usc_remote

/* File: verif/tb_uart_status_control.sv */
// tb_uart_status_control: self-checking bench of usc_top
// assumes: usc_pkg and usc_remote compiled first
`timescale 1ns/100ps
module tb_uart_status_control;
  localparam logic [3:0] STA = usc_pkg::A_STA;
  localparam logic [3:0] MOD = usc_pkg::A_MODE;
  localparam logic [3:0] TXD = usc_pkg::A_TXD;
  localparam logic [3:0] RXD = usc_pkg::A_RXD;
  localparam logic [3:0] IST = usc_pkg::A_IST;
  localparam logic [3:0] ICL = usc_pkg::A_ICLR;
  logic        CORE_CLK, NRST, WR, RD, RX_PIN, TX_PIN_O, TX_PIN_OE, IRQ;
  logic [3:0]  ADDR;
  logic [15:0] WDATA, RDATA;
  logic [7:0]  d[5];
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          seed = 94;
  usc_top DUT (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RX_PIN(RX_PIN), .TX_PIN_O(TX_PIN_O),
    .TX_PIN_OE(TX_PIN_OE), .IRQ(IRQ));
  usc_remote rem (.clk(CORE_CLK), .tx_o(TX_PIN_O), .tx_oe(TX_PIN_OE), .rx_line(RX_PIN));
  // ----------------
  // clock and helpers
  // ----------------
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    tick(1);
    WR <= 1'b0;
    tick(1);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] k, input logic [15:0] e,
                      input string m);
    ADDR <= a;
    RD <= 1'b1;
    tick(1);
    RD <= 1'b0;
    #1 chk(RDATA & k, e, m);
    tick(1);
  endtask
  // pin bits: 0 level, 1 enable, 2 irq
  task automatic pins(input logic [15:0] k, input logic [15:0] e, input string m);
    #1 chk({13'h0000, IRQ, TX_PIN_OE, TX_PIN_O} & k, e, m);
    tick(1);
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 4000 && rem.got_q.size() < n; i++) tick(1);
    tick(30);
  endtask
  function automatic logic [11:0] frm(input logic [8:0] v, input logic s, input int nb);
    frm = 12'hFFF;
    frm[0] = 1'b0;
    for (int i = 0; i < nb; i++) frm[i + 1] = v[i];
    frm[nb + 1] = s;
  endfunction
  // ----------
  // scenarios
  // ----------
  initial begin
    NRST = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 16'h0000;
    tick(5);
    NRST <= 1'b1;
    tick(1);
    rchk(STA, 16'hFFFF, 16'h0110, "sta rst");
    pins(16'h0007, 16'h0001, "pin rst");
    wr(STA, 16'hF3FF);
    rchk(STA, 16'hFFFF, 16'hE1F0, "fields");
    rchk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
    wr(MOD, 16'h1000);
    wr(STA, 16'h4400);
    pins(16'h0003, 16'h0003, "ir hi");
    wr(STA, 16'h0400);
    pins(16'h0003, 16'h0002, "ir lo");
    wr(MOD, 16'h0000);
    wr(STA, 16'h0000);
    // idle-low ir level looks like a start bit to the far end; let it drain
    tick(160);
    rem.got_q.delete();
    $display("test regs ends");
    for (int i = 0; i < 5; i++) begin
      d[i] = 8'($random(seed));
      wr(TXD, {8'h00, d[i]});
    end
    rchk(STA, 16'h0300, 16'h0200, "tx full");
    wr(ICL, 16'h0007);
    wr(STA, 16'h2400);
    wait_q(4);
    tick(200);
    chk(16'(rem.got_q.size()), 16'h0004, "tx cnt");
    for (int i = 0; i < 4; i++) chk({7'h00, rem.got_q[i]}, {8'h01, d[i]}, "tx dat");
    rchk(STA, 16'h0300, 16'h0100, "tx empty");
    rchk(IST, 16'h0007, 16'h0001, "done ev");
    pins(16'h0004, 16'h0000, "irq mask");
    wr(usc_pkg::A_IEN, 16'h0001);
    pins(16'h0004, 16'h0004, "irq on");
    wr(ICL, 16'h0001);
    pins(16'h0004, 16'h0000, "irq clr");
    for (int m = 0; m < 4; m++) begin
      wr(STA, {m[1], 1'b0, m[0], 13'h0400});
      wr(ICL, 16'h0001);
      rem.got_q.delete();
      wr(TXD, {8'h00, d[m]});
      tick(4);
      rchk(IST, 16'h0001, {15'h0000, m[0] == 1'b0}, "load ev");
      wait_q(1);
      rchk(IST, 16'h0001, {15'h0000, m != 3}, "end ev");
    end
    wr(TXD, 16'h00F0);
    wr(TXD, 16'h000F);
    tick(40);
    wr(STA, 16'h0000);
    pins(16'h0002, 16'h0000, "oe off");
    rchk(STA, 16'h0300, 16'h0100, "abort");
    $display("test tx ends");
    tick(200);
    rem.got_q.delete();
    rem.max_low = 0;
    wr(STA, 16'h0C00);
    wr(TXD, {8'h00, d[4]});
    wr(TXD, 16'h0055);
    wait_q(2);
    chk(16'(rem.max_low), 16'h00D0, "brk len");
    chk({7'h00, rem.got_q[1]}, 16'h0155, "sync");
    rchk(STA, 16'h0800, 16'h0000, "brk clr");
    $display("test break ends");
    wr(STA, 16'h0080);
    wr(ICL, 16'h0007);
    for (int i = 0; i < 5; i++) begin
      d[i] = 8'($random(seed));
      fork
        rem.send(frm({1'b0, d[i]}, 1'b1, 8), 10);
        if (i == 0) begin
          tick(60);
          rchk(STA, 16'h0010, 16'h0000, "rx busy");
        end
      join
      tick(4);
      if (i < 4) rchk(IST, 16'h0002, {14'h0000, i > 1, 1'b0}, "rx ev");
      if (i == 2) begin
        wr(ICL, 16'h0007);
        wr(STA, 16'h00C0);
      end
    end
    rchk(STA, 16'h0003, 16'h0003, "overrun");
    rchk(IST, 16'h0004, 16'h0004, "ovr ev");
    rchk(RXD, 16'h01FF, {8'h00, d[0]}, "rx d0");
    rchk(RXD, 16'h01FF, {8'h00, d[1]}, "rx d1");
    wr(STA, 16'h0000);
    rchk(STA, 16'h0013, 16'h0010, "ovr clr");
    $display("test rx ends");
    for (int f = 1; f < 3; f++) begin
      wr(MOD, {13'h0000, f[1:0], 1'b0});
      wr(ICL, 16'h0007);
      d[0] = 8'($random(seed));
      rem.send(frm({^d[0] ^ f[0], d[0]}, 1'b1, 9), 11);
      rem.send(frm({^d[0] ^ f[1], d[0]}, 1'b0, 9), 11);
      tick(4);
      rchk(IST, 16'h0002, 16'h0002, "each ev");
      rchk(STA, 16'h000D, 16'h0009, "parity_error_flag");
      rchk(RXD, 16'h00FF, {8'h00, d[0]}, "pe dat");
      rchk(STA, 16'h000D, 16'h0005, "framing_error_flag");
      rchk(RXD, 16'h00FF, {8'h00, d[0]}, "fe dat");
      rchk(STA, 16'h000D, 16'h0000, "empty");
    end
    wr(MOD, 16'h0006);
    wr(STA, 16'h0020);
    rem.send(frm({1'b0, d[2]}, 1'b1, 9), 11);
    rem.send(frm({1'b1, d[3]}, 1'b1, 9), 11);
    tick(4);
    rchk(RXD, 16'h01FF, {8'h01, d[3]}, "addr");
    rchk(STA, 16'h0001, 16'h0000, "addr one");
    wr(MOD, 16'h0000);
    rem.send(frm({1'b0, d[2]}, 1'b1, 8), 10);
    tick(4);
    rchk(RXD, 16'h01FF, {8'h00, d[2]}, "addr 8b");
    $display("test format ends");
    conclude();
  end
endmodule // tb_uart_status_control
